// [hdl/cct_pkg.sv]
// Constants, register map and field layout for the cascaded compare timer.
// Assumes a 32-bit APB master; every register sits in the low byte of an aligned word.
//
// Contract
// - Upper select: 0xx overflow, 1xx internal clocks
// - Lower select: 0xx event, 100-110 prescaler clocks
// - Lower select 111 counts subclock divided four
// - Overflow flag bit 7 sets on overflow
// - Match flag bit 6 sets on compare equal
// - Bit 5 gates overflow interrupt requests
// - Bit 4 clears counter on compare match
// - Upper byte counts lower-half overflows when cascaded
// - Two compare bytes form 16-bit match value
// - Enable two bit 3 gates timer requests
// - Request two bit 3 flags timer request
// - Upper select top bit zero: one 16-bit timer
// - Reset: counter zero, compare ones, controls zero
// - Overflow request needs both enables set
// - 16-bit access upper first through temporary latch

package cct_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int INDEX_W = 16;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int CNT_W = 16;

	// ----------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [INDEX_W-1:0] IDX_TIMER_CONTROL = 16'hffb6;
	localparam logic [INDEX_W-1:0] IDX_TIMER_CONTROL_STATUS = 16'hffb7;
	localparam logic [INDEX_W-1:0] IDX_COUNTER_HIGH_BYTE = 16'hffb8;
	localparam logic [INDEX_W-1:0] IDX_COUNTER_LOW_BYTE = 16'hffb9;
	localparam logic [INDEX_W-1:0] IDX_COMPARE_HIGH_BYTE = 16'hffba;
	localparam logic [INDEX_W-1:0] IDX_COMPARE_LOW_BYTE = 16'hffbb;
	localparam logic [INDEX_W-1:0] IDX_EVENT_STATUS = 16'hffc0;
	localparam logic [INDEX_W-1:0] IDX_EVENT_CLEAR = 16'hffc1;
	localparam logic [INDEX_W-1:0] IDX_EVENT_ENABLE = 16'hffc2;
	localparam logic [INDEX_W-1:0] IDX_INTERRUPT_ENABLE_TWO = 16'hfff4;
	localparam logic [INDEX_W-1:0] IDX_INTERRUPT_REQUEST_TWO = 16'hfff7;

	typedef enum logic [3:0] {
		CCT_REG_NONE,
		CCT_REG_CTRL,
		CCT_REG_CSR,
		CCT_REG_CNT_HI,
		CCT_REG_CNT_LO,
		CCT_REG_CMP_HI,
		CCT_REG_CMP_LO,
		CCT_REG_EV_STAT,
		CCT_REG_EV_CLR,
		CCT_REG_EV_EN,
		CCT_REG_IEN2,
		CCT_REG_IRQ2
	} cct_reg_e;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int SEL_W = 3;
	localparam int HIGH_SEL_LSB = 4;
	localparam int LOW_SEL_LSB = 0;
	localparam int OVF_FLAG_BIT = 7;
	localparam int MATCH_FLAG_BIT = 6;
	localparam int OVF_IE_BIT = 5;
	localparam int CLR_MATCH_BIT = 4;
	localparam int TIMER_IE_BIT = 3;
	localparam int TIMER_REQ_BIT = 3;
	localparam int SEL_TOP_BIT = 2;

	localparam logic [SEL_W-1:0] SEL_DIV32 = 3'h4;
	localparam logic [SEL_W-1:0] SEL_DIV16 = 3'h5;
	localparam logic [SEL_W-1:0] SEL_DIV4 = 3'h6;
	localparam logic [SEL_W-1:0] SEL_SUB4 = 3'h7;

	// Event status layout
	localparam int EV_W = 3;
	localparam int EV_OVF = 0;
	localparam int EV_MATCH = 1;
	localparam int EV_REQ = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [CNT_W-1:0] COUNTER_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] COMPARE_RESET = 16'hffff;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;
	localparam logic [BYTE_W-1:0] BYTE_FULL = 8'hff;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
	localparam logic [EV_W-1:0] EV_RESET = 3'h0;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	localparam int PRE_W = 5;
	localparam logic [PRE_W-1:0] PRE_MASK_DIV4 = 5'h03;
	localparam logic [PRE_W-1:0] PRE_MASK_DIV16 = 5'h0f;
	localparam logic [PRE_W-1:0] PRE_MASK_DIV32 = 5'h1f;
	localparam logic [PRE_W-1:0] PRE_RESET = 5'h00;
	localparam logic [PRE_W-1:0] PRE_ONE = 5'h01;
	localparam int SUB_W = 2;
	localparam logic [SUB_W-1:0] SUB_LAST = 2'h3;
	localparam logic [SUB_W-1:0] SUB_RESET = 2'h0;
	localparam logic [SUB_W-1:0] SUB_ONE = 2'h1;

endpackage

// [hdl/cct_prescaler.sv]
// Clock-enable generator for the cascaded compare timer.
// Assumes sub_clock is a slow level synchronous to clock.
`timescale 1ns/100ps
`default_nettype none

module cct_prescaler
	import cct_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sub_clock,
	output logic tick_div4,
	output logic tick_div16,
	output logic tick_div32,
	output logic tick_sub4
);

	logic [PRE_W-1:0] pre_reg;
	logic [SUB_W-1:0] sub_cnt_reg;
	logic sub_prev_reg;
	logic sub_rise;

	// ----------------------------------------
	// System clock divider
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pre_reg <= PRE_RESET;
		end else begin
			pre_reg <= pre_reg + PRE_ONE;
		end
	end

	assign tick_div4 = (pre_reg & PRE_MASK_DIV4) == PRE_MASK_DIV4;
	assign tick_div16 = (pre_reg & PRE_MASK_DIV16) == PRE_MASK_DIV16;
	assign tick_div32 = (pre_reg & PRE_MASK_DIV32) == PRE_MASK_DIV32;

	// ----------------------------------------
	// Subclock divided by four, one pulse per fourth rising edge
	// ----------------------------------------
	assign sub_rise = sub_clock && !sub_prev_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sub_prev_reg <= 1'b0;
			sub_cnt_reg <= SUB_RESET;
		end else begin
			sub_prev_reg <= sub_clock;
			if (sub_rise) begin
				sub_cnt_reg <= sub_cnt_reg + SUB_ONE;
			end
		end
	end

	assign tick_sub4 = sub_rise && (sub_cnt_reg == SUB_LAST);

endmodule

`default_nettype wire

// [hdl/cct_timer.sv]
// Cascaded 16-bit compare timer with an APB register slave and interrupt.
// Assumes one 100 MHz clock; ext_event and sub_clock are synchronous levels.
`timescale 1ns/100ps
`default_nettype none

module cct_timer
	import cct_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_event,
	input wire logic sub_clock,
	output logic irq
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic cct_reg_e reg_decode(input logic [ADDR_W-1:0] addr);
		cct_reg_e sel;
		sel = CCT_REG_NONE;
		if (addr[1:0] == 2'h0) begin
			unique case (addr[ADDR_W-1:2])
				IDX_TIMER_CONTROL: sel = CCT_REG_CTRL;
				IDX_TIMER_CONTROL_STATUS: sel = CCT_REG_CSR;
				IDX_COUNTER_HIGH_BYTE: sel = CCT_REG_CNT_HI;
				IDX_COUNTER_LOW_BYTE: sel = CCT_REG_CNT_LO;
				IDX_COMPARE_HIGH_BYTE: sel = CCT_REG_CMP_HI;
				IDX_COMPARE_LOW_BYTE: sel = CCT_REG_CMP_LO;
				IDX_EVENT_STATUS: sel = CCT_REG_EV_STAT;
				IDX_EVENT_CLEAR: sel = CCT_REG_EV_CLR;
				IDX_EVENT_ENABLE: sel = CCT_REG_EV_EN;
				IDX_INTERRUPT_ENABLE_TWO: sel = CCT_REG_IEN2;
				IDX_INTERRUPT_REQUEST_TWO: sel = CCT_REG_IRQ2;
				default: sel = CCT_REG_NONE;
			endcase
		end
		return sel;
	endfunction

	// Top bit clear picks the alternate source, otherwise a divided clock
	function automatic logic pick_tick(
		input logic [SEL_W-1:0] code,
		input logic alt,
		input logic d32,
		input logic d16,
		input logic d4,
		input logic s4
	);
		logic t;
		t = alt;
		unique case (code)
			SEL_DIV32: t = d32;
			SEL_DIV16: t = d16;
			SEL_DIV4: t = d4;
			SEL_SUB4: t = s4;
			default: t = alt;
		endcase
		return t;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [SEL_W-1:0] high_clock_select_reg;
	logic [SEL_W-1:0] low_clock_select_reg;
	logic overflow_flag_reg;
	logic match_flag_reg;
	logic overflow_irq_enable_reg;
	logic clear_on_match_reg;
	logic timer_irq_enable_reg;
	logic timer_irq_request_reg;
	logic [CNT_W-1:0] cascaded_counter_reg;
	logic [CNT_W-1:0] cascaded_counter_next;
	logic [CNT_W-1:0] compare_value_reg;
	logic [BYTE_W-1:0] temp_reg;
	logic [BYTE_W-1:0] snap_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic [EV_W-1:0] ev_status_reg;
	logic [EV_W-1:0] ev_enable_reg;
	logic [EV_W-1:0] ev_set;
	logic ext_prev_reg;
	logic ext_rise;
	logic tick_div4;
	logic tick_div16;
	logic tick_div32;
	logic tick_sub4;
	logic cascaded;
	logic low_tick;
	logic low_ovf;
	logic high_tick;
	logic counter_equal;
	logic match_evt;
	logic ovf_evt;
	logic req_evt;
	logic bus_setup;
	logic bus_access;
	logic wr_en;
	logic rd_en;
	cct_reg_e acc_sel;
	logic [BYTE_W-1:0] wbyte;
	logic [BYTE_W-1:0] rd_byte;

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	assign acc_sel = reg_decode(paddr);
	assign bus_setup = psel && !penable;
	assign bus_access = psel && penable;
	assign wr_en = bus_access && pwrite && (acc_sel != CCT_REG_NONE);
	assign rd_en = bus_access && !pwrite && (acc_sel != CCT_REG_NONE);
	assign wbyte = pwdata[BYTE_W-1:0];
	assign pready = 1'b1;
	assign pslverr = bus_access && (acc_sel == CCT_REG_NONE);
	assign prdata = prdata_reg;
	assign cascaded = !high_clock_select_reg[SEL_TOP_BIT];

	always_comb begin
		rd_byte = BYTE_ZERO;
		unique case (acc_sel)
			CCT_REG_CTRL: begin
				rd_byte[HIGH_SEL_LSB +: SEL_W] = high_clock_select_reg;
				rd_byte[LOW_SEL_LSB +: SEL_W] = low_clock_select_reg;
			end
			CCT_REG_CSR: begin
				rd_byte[OVF_FLAG_BIT] = overflow_flag_reg;
				rd_byte[MATCH_FLAG_BIT] = match_flag_reg;
				rd_byte[OVF_IE_BIT] = overflow_irq_enable_reg;
				rd_byte[CLR_MATCH_BIT] = clear_on_match_reg;
			end
			CCT_REG_CNT_HI: rd_byte = cascaded_counter_reg[CNT_W-1:BYTE_W];
			CCT_REG_CNT_LO: rd_byte = cascaded ? temp_reg : cascaded_counter_reg[BYTE_W-1:0];
			CCT_REG_CMP_HI: rd_byte = compare_value_reg[CNT_W-1:BYTE_W];
			CCT_REG_CMP_LO: rd_byte = compare_value_reg[BYTE_W-1:0];
			CCT_REG_EV_STAT: rd_byte[EV_W-1:0] = ev_status_reg;
			CCT_REG_EV_EN: rd_byte[EV_W-1:0] = ev_enable_reg;
			CCT_REG_IEN2: rd_byte[TIMER_IE_BIT] = timer_irq_enable_reg;
			CCT_REG_IRQ2: rd_byte[TIMER_REQ_BIT] = timer_irq_request_reg;
			default: rd_byte = BYTE_ZERO;
		endcase
	end

	// Read data and the low-byte snapshot are taken in the setup cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prdata_reg <= '0;
			snap_reg <= BYTE_ZERO;
		end else if (bus_setup) begin
			prdata_reg <= DATA_W'(rd_byte);
			snap_reg <= cascaded_counter_reg[BYTE_W-1:0];
		end
	end

	// ----------------------------------------
	// Temporary latch for 16-bit byte pairs
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			temp_reg <= BYTE_ZERO;
		end else if (cascaded) begin
			if (wr_en && (acc_sel == CCT_REG_CNT_HI || acc_sel == CCT_REG_CMP_HI)) begin
				temp_reg <= wbyte;
			end else if (rd_en && acc_sel == CCT_REG_CNT_HI) begin
				temp_reg <= snap_reg;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			high_clock_select_reg <= SEL_RESET;
			low_clock_select_reg <= SEL_RESET;
		end else if (wr_en && acc_sel == CCT_REG_CTRL) begin
			high_clock_select_reg <= wbyte[HIGH_SEL_LSB +: SEL_W];
			low_clock_select_reg <= wbyte[LOW_SEL_LSB +: SEL_W];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			overflow_irq_enable_reg <= 1'b0;
			clear_on_match_reg <= 1'b0;
		end else if (wr_en && acc_sel == CCT_REG_CSR) begin
			overflow_irq_enable_reg <= wbyte[OVF_IE_BIT];
			clear_on_match_reg <= wbyte[CLR_MATCH_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer_irq_enable_reg <= 1'b0;
		end else if (wr_en && acc_sel == CCT_REG_IEN2) begin
			timer_irq_enable_reg <= wbyte[TIMER_IE_BIT];
		end
	end

	// ----------------------------------------
	// Count sources
	// ----------------------------------------
	cct_prescaler u_prescaler (
		.clock(clock),
		.rst_n(rst_n),
		.sub_clock(sub_clock),
		.tick_div4(tick_div4),
		.tick_div16(tick_div16),
		.tick_div32(tick_div32),
		.tick_sub4(tick_sub4)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_event;
		end
	end

	assign ext_rise = ext_event && !ext_prev_reg;

	// Code 011 is not a legal setting; it behaves as the alternate source
	assign low_tick = pick_tick(low_clock_select_reg, ext_rise, tick_div32, tick_div16, tick_div4,
		tick_sub4);
	assign low_ovf = low_tick && (cascaded_counter_reg[BYTE_W-1:0] == BYTE_FULL);
	assign high_tick = pick_tick(high_clock_select_reg, low_ovf, tick_div32, tick_div16, tick_div4,
		tick_sub4);

	// ----------------------------------------
	// Compare and overflow events
	// ----------------------------------------
	assign counter_equal = cascaded_counter_reg == compare_value_reg;

	// A compare low write or a counter low write in the same cycle masks the match event
	assign match_evt = low_tick && counter_equal && !(wr_en && acc_sel == CCT_REG_CMP_LO)
		&& !(wr_en && acc_sel == CCT_REG_CNT_LO);
	assign ovf_evt = high_tick && (cascaded_counter_reg[CNT_W-1:BYTE_W] == BYTE_FULL)
		&& !(match_evt && clear_on_match_reg)
		&& !(wr_en && (acc_sel == CCT_REG_CNT_LO || acc_sel == CCT_REG_CNT_HI));
	assign req_evt = timer_irq_enable_reg
		&& (match_evt || (ovf_evt && overflow_irq_enable_reg));

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_comb begin
		cascaded_counter_next = cascaded_counter_reg;
		if (low_tick) begin
			cascaded_counter_next[BYTE_W-1:0] = cascaded_counter_reg[BYTE_W-1:0] + BYTE_ONE;
		end
		if (high_tick) begin
			cascaded_counter_next[CNT_W-1:BYTE_W] = cascaded_counter_reg[CNT_W-1:BYTE_W] + BYTE_ONE;
		end
		if (match_evt && clear_on_match_reg) begin
			cascaded_counter_next = COUNTER_RESET;
		end
		if (wr_en && acc_sel == CCT_REG_CNT_LO) begin
			cascaded_counter_next[BYTE_W-1:0] = wbyte;
			if (cascaded) begin
				cascaded_counter_next[CNT_W-1:BYTE_W] = temp_reg;
			end
		end
		if (wr_en && acc_sel == CCT_REG_CNT_HI && !cascaded) begin
			cascaded_counter_next[CNT_W-1:BYTE_W] = wbyte;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cascaded_counter_reg <= COUNTER_RESET;
		end else begin
			cascaded_counter_reg <= cascaded_counter_next;
		end
	end

	// ----------------------------------------
	// Compare register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			compare_value_reg <= COMPARE_RESET;
		end else if (wr_en && acc_sel == CCT_REG_CMP_LO) begin
			compare_value_reg[BYTE_W-1:0] <= wbyte;
			if (cascaded) begin
				compare_value_reg[CNT_W-1:BYTE_W] <= temp_reg;
			end
		end else if (wr_en && acc_sel == CCT_REG_CMP_HI && !cascaded) begin
			compare_value_reg[CNT_W-1:BYTE_W] <= wbyte;
		end
	end

	// ----------------------------------------
	// Status flags, set wins over a written zero
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			overflow_flag_reg <= 1'b0;
		end else if (ovf_evt) begin
			overflow_flag_reg <= 1'b1;
		end else if (wr_en && acc_sel == CCT_REG_CSR && !wbyte[OVF_FLAG_BIT]) begin
			overflow_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			match_flag_reg <= 1'b0;
		end else if (match_evt) begin
			match_flag_reg <= 1'b1;
		end else if (wr_en && acc_sel == CCT_REG_CSR && !wbyte[MATCH_FLAG_BIT]) begin
			match_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer_irq_request_reg <= 1'b0;
		end else if (req_evt) begin
			timer_irq_request_reg <= 1'b1;
		end else if (wr_en && acc_sel == CCT_REG_IRQ2 && !wbyte[TIMER_REQ_BIT]) begin
			timer_irq_request_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt status, clear and enable
	// ----------------------------------------
	always_comb begin
		ev_set = EV_RESET;
		ev_set[EV_OVF] = ovf_evt;
		ev_set[EV_MATCH] = match_evt;
		ev_set[EV_REQ] = req_evt;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ev_status_reg <= EV_RESET;
		end else if (wr_en && acc_sel == CCT_REG_EV_CLR) begin
			ev_status_reg <= (ev_status_reg & ~wbyte[EV_W-1:0]) | ev_set;
		end else begin
			ev_status_reg <= ev_status_reg | ev_set;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ev_enable_reg <= EV_RESET;
		end else if (wr_en && acc_sel == CCT_REG_EV_EN) begin
			ev_enable_reg <= wbyte[EV_W-1:0];
		end
	end

	assign irq = |(ev_status_reg & ev_enable_reg);

endmodule

`default_nettype wire

// [sim/cct_checker.sv]
// Port-level concurrent checks for the cascaded compare timer.
// Assumes one clock and a synchronous active-low reset; bound to every cct_timer.
`timescale 1ns/100ps
`default_nettype none

module cct_checker
	import cct_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_event,
	input wire logic sub_clock,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_ready_high: assert property (psel |-> pready)
		else $error("pready low in a transfer");
	chk_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	chk_err_mapped: assert property (psel && penable && paddr == {IDX_TIMER_CONTROL, 2'b00} |-> !pslverr)
		else $error("mapped access refused");
	chk_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	chk_rdata_hold: assert property (psel && penable |=> $stable(prdata))
		else $error("read data changed after access");
	chk_ctrl_reserved: assert property (psel && !penable && !pwrite && paddr == {IDX_TIMER_CONTROL, 2'b00}
		|=> prdata[7] == 1'b0 && prdata[3] == 1'b0)
		else $error("control reserved bits read one");
	chk_csr_low_zero: assert property (psel && !penable && !pwrite && paddr == {IDX_TIMER_CONTROL_STATUS, 2'b00}
		|=> prdata[3:0] == 4'h0)
		else $error("status low bits read one");
	chk_clear_reads_zero: assert property (psel && !penable && !pwrite && paddr == {IDX_EVENT_CLEAR, 2'b00}
		|=> prdata == 32'h0000_0000)
		else $error("clear register read nonzero");
	chk_misalign_zero: assert property (psel && !penable && !pwrite && paddr[1:0] != 2'b00
		|=> prdata == 32'h0000_0000)
		else $error("misaligned read returned data");
	chk_irq_reset: assert property ($rose(rst_n) |-> !irq)
		else $error("irq high after reset");
	chk_irq_masked: assert property (psel && penable && pwrite && paddr == {IDX_EVENT_ENABLE, 2'b00}
		&& pwdata[2:0] == 3'h0 |=> !irq)
		else $error("irq high with all enables off");
endmodule

bind cct_timer cct_checker chk_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_event(ext_event),
	.sub_clock(sub_clock), .irq(irq));
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the cascaded compare timer.
// Drives the APB port, the event input and the subclock level directly.
`timescale 1ns/100ps
`default_nettype none

module tb
	import cct_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic ext_event = 1'b0;
	logic sub_clock = 1'b0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	int mismatches = 0;
	int n_compared = 0;
	logic [2:0] sub_cnt = 3'h0;
	logic [15:0] rs_idx [11] = '{IDX_TIMER_CONTROL, IDX_TIMER_CONTROL_STATUS, IDX_COUNTER_HIGH_BYTE,
		IDX_COUNTER_LOW_BYTE, IDX_COMPARE_HIGH_BYTE, IDX_COMPARE_LOW_BYTE, IDX_INTERRUPT_ENABLE_TWO,
		IDX_INTERRUPT_REQUEST_TWO, IDX_EVENT_STATUS, IDX_EVENT_ENABLE, IDX_EVENT_CLEAR};
	logic [7:0] rs_val [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] dv_ctrl [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h40, 8'h50, 8'h60, 8'h70};
	logic [15:0] dv_exp [8] = '{16'h0004, 16'h0008, 16'h0020, 16'h0004, 16'h0400, 16'h0800, 16'h2000, 16'h0400};

	cct_timer dut_u (
		.clock(clock),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ext_event(ext_event),
		.sub_clock(sub_clock),
		.irq(irq)
	);

	always #5 clock = ~clock;

	// Subclock level with a period of eight system clocks
	always @(posedge clock) begin
		sub_cnt <= sub_cnt + 3'h1;
		sub_clock <= sub_cnt[2];
	end

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, wd};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
		@(posedge clock);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, {idx, 2'b00}, d, r, e);
	endtask

	task automatic rd(input logic [15:0] idx, output logic [31:0] d);
		logic e;
		apb(1'b0, {idx, 2'b00}, 8'h00, d, e);
	endtask

	task automatic cr(input string what, input logic [15:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		rd(idx, d);
		check(what, d, {24'h00_0000, exp});
	endtask

	task automatic wr16(input logic [15:0] v);
		wr(IDX_COUNTER_HIGH_BYTE, v[15:8]);
		wr(IDX_COUNTER_LOW_BYTE, v[7:0]);
	endtask

	task automatic rd16(output logic [15:0] v);
		logic [31:0] h;
		logic [31:0] l;
		rd(IDX_COUNTER_HIGH_BYTE, h);
		rd(IDX_COUNTER_LOW_BYTE, l);
		v = {h[7:0], l[7:0]};
	endtask

	task automatic c16(input string what, input logic [15:0] exp);
		logic [15:0] v;
		rd16(v);
		check(what, {16'h0000, v}, {16'h0000, exp});
	endtask

	// Counting window of exactly 128 clocks under one control setting
	task automatic run128(input logic [7:0] c);
		wr(IDX_TIMER_CONTROL, c);
		repeat (125) @(posedge clock);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	task automatic pulse;
		ext_event <= 1'b1;
		repeat (3) @(posedge clock);
		ext_event <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic e;
		check("irq_idle", 32'(irq), 32'h0000_0000);
		for (int i = 0; i < 11; i++) begin
			cr("reset_value", rs_idx[i], rs_val[i]);
		end
		apb(1'b1, {IDX_TIMER_CONTROL, 2'b01}, 8'hff, d, e);
		check("misalign_err", 32'(e), 32'h0000_0001);
		apb(1'b0, {IDX_TIMER_CONTROL, 2'b01}, 8'h00, d, e);
		check("misalign_data", d, 32'h0000_0000);
		cr("ctrl_kept", IDX_TIMER_CONTROL, 8'h00);
		apb(1'b0, 18'h3_fec0, 8'h00, d, e);
		check("unmapped_err", 32'(e), 32'h0000_0001);
		wr(IDX_TIMER_CONTROL, 8'h8f);
		cr("ctrl_reserved", IDX_TIMER_CONTROL, 8'h07);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	task automatic t_divide;
		logic [15:0] v;
		for (int i = 0; i < 8; i++) begin
			wr16(16'h0000);
			run128(dv_ctrl[i]);
			rd16(v);
			check("tick_count", {16'h0000, v}, {16'h0000, dv_exp[i]});
		end
	endtask

	// Byte accesses bypass the latch when the halves run apart
	task automatic t_direct;
		wr(IDX_COMPARE_HIGH_BYTE, 8'h11);
		wr(IDX_COMPARE_LOW_BYTE, 8'h22);
		wr(IDX_COMPARE_HIGH_BYTE, 8'h33);
		wr(IDX_TIMER_CONTROL, 8'h40);
		wr(IDX_COMPARE_LOW_BYTE, 8'h44);
		cr("direct_cmp_hi", IDX_COMPARE_HIGH_BYTE, 8'h11);
		cr("direct_cmp_lo", IDX_COMPARE_LOW_BYTE, 8'h44);
		wr(IDX_COMPARE_HIGH_BYTE, 8'h55);
		cr("direct_cmp_hi2", IDX_COMPARE_HIGH_BYTE, 8'h55);
		wr(IDX_COUNTER_LOW_BYTE, 8'h66);
		cr("direct_cnt_lo", IDX_COUNTER_LOW_BYTE, 8'h66);
		wr(IDX_TIMER_CONTROL, 8'h00);
	endtask

	task automatic t_cascade;
		wr(IDX_COMPARE_HIGH_BYTE, 8'h12);
		wr(IDX_COMPARE_LOW_BYTE, 8'h34);
		cr("cmp_hi", IDX_COMPARE_HIGH_BYTE, 8'h12);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h00);
		wr(IDX_INTERRUPT_ENABLE_TWO, 8'h08);
		wr(IDX_EVENT_ENABLE, 8'h01);
		wr(IDX_EVENT_CLEAR, 8'h07);
		wr16(16'h00ff);
		cr("latch_hi", IDX_COUNTER_HIGH_BYTE, 8'h00);
		pulse();
		cr("latched_lo", IDX_COUNTER_LOW_BYTE, 8'hff);
		c16("carry", 16'h0100);
		cr("no_ovf", IDX_TIMER_CONTROL_STATUS, 8'h00);
		wr16(16'hffff);
		pulse();
		c16("wrap", 16'h0000);
		cr("ovf_set", IDX_TIMER_CONTROL_STATUS, 8'h80);
		cr("ovf_gated", IDX_INTERRUPT_REQUEST_TWO, 8'h00);
		check("irq_ovf", 32'(irq), 32'h0000_0001);
		wr(IDX_EVENT_ENABLE, 8'h00);
		check("irq_masked", 32'(irq), 32'h0000_0000);
		wr(IDX_EVENT_ENABLE, 8'h01);
		wr(IDX_EVENT_CLEAR, 8'h01);
		check("irq_cleared", 32'(irq), 32'h0000_0000);
		cr("ev_status", IDX_EVENT_STATUS, 8'h00);
		wr(IDX_TIMER_CONTROL_STATUS, 8'ha0);
		cr("ovf_kept", IDX_TIMER_CONTROL_STATUS, 8'ha0);
		wr16(16'hffff);
		pulse();
		cr("ovf_request", IDX_INTERRUPT_REQUEST_TWO, 8'h08);
	endtask

	task automatic t_match;
		logic [15:0] v;
		int n;
		wr(IDX_INTERRUPT_ENABLE_TWO, 8'h00);
		wr(IDX_INTERRUPT_REQUEST_TWO, 8'h00);
		wr(IDX_COMPARE_HIGH_BYTE, 8'h00);
		wr(IDX_COMPARE_LOW_BYTE, 8'h02);
		wr16(16'h0000);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h00);
		run128(8'h06);
		c16("free_run", 16'h0020);
		cr("match_set", IDX_TIMER_CONTROL_STATUS, 8'h40);
		cr("req_gated", IDX_INTERRUPT_REQUEST_TWO, 8'h00);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h10);
		wr16(16'h0000);
		wr(IDX_INTERRUPT_ENABLE_TWO, 8'h08);
		wr(IDX_EVENT_ENABLE, 8'h02);
		wr(IDX_EVENT_CLEAR, 8'h07);
		wr(IDX_TIMER_CONTROL, 8'h06);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge clock);
			n++;
		end
		wr(IDX_TIMER_CONTROL, 8'h00);
		check("irq_match", 32'(irq), 32'h0000_0001);
		if (irq !== 1'b1) begin
			print_verdict();
		end
		cr("match_clr", IDX_TIMER_CONTROL_STATUS, 8'h50);
		rd16(v);
		check("clear_bound", 32'(v <= 16'h0002), 32'h0000_0001);
		cr("req_set", IDX_INTERRUPT_REQUEST_TWO, 8'h08);
		wr(IDX_TIMER_CONTROL_STATUS, 8'hd0);
		cr("ones_ignored", IDX_TIMER_CONTROL_STATUS, 8'h50);
		wr(IDX_INTERRUPT_REQUEST_TWO, 8'h00);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h10);
		cr("handler_csr", IDX_TIMER_CONTROL_STATUS, 8'h10);
		cr("handler_req", IDX_INTERRUPT_REQUEST_TWO, 8'h00);
		wr(IDX_EVENT_CLEAR, 8'h02);
		check("irq_done", 32'(irq), 32'h0000_0000);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_divide();
		t_direct();
		t_cascade();
		t_match();
		print_verdict();
	end
endmodule
`default_nettype wire
